// ---- shared/tws_pkg.sv ----
// Package for the two-wire clocked serial port: register map, field
// positions, reset values and shift counts shared by both ends.
// Assumes an 8-bit register port and 8-bit MSB-first transfers.
package tws_pkg;

  // Register addresses
  localparam logic [15:0] TWS_ADDR_MODE = 16'hFF60;
  localparam logic [15:0] TWS_ADDR_BUSCTL = 16'hFF61;
  localparam logic [15:0] TWS_ADDR_ITC = 16'hFF62;
  localparam logic [15:0] TWS_ADDR_SHIFT = 16'hFF63;
  localparam logic [15:0] TWS_ADDR_SVA = 16'hFF64;

  // Reset values
  localparam logic [7:0] TWS_MODE_RST = 8'h00;
  localparam logic [7:0] TWS_BUSCTL_RST = 8'h00;
  localparam logic [7:0] TWS_ITC_RST = 8'h00;
  localparam logic [7:0] TWS_SHIFT_RST = 8'h00;
  localparam logic [7:0] TWS_SVA_RST = 8'h00;

  // Field positions in serial_mode_control
  localparam int TWS_B_ENABLE = 7;
  localparam int TWS_B_COMPARE = 6;
  localparam int TWS_B_WAKEUP = 5;
  localparam int TWS_B_MODE_HIGH = 4;
  localparam int TWS_B_MODE_MID = 3;
  localparam int TWS_B_MODE_LOW = 2;
  localparam int TWS_B_CLKSEL_HIGH = 1;
  localparam int TWS_B_CLKSEL_LOW = 0;

  // Field positions in bus_interface_control and interrupt_timing_control
  localparam int TWS_B_RELEASE = 0;
  localparam int TWS_B_COMMAND = 1;
  localparam int TWS_B_CLK_LEVEL = 6;

  // Writable masks
  localparam logic [7:0] TWS_MODE_WMASK = 8'hBF;
  localparam logic [7:0] TWS_BUSCTL_WMASK = 8'hFC;
  localparam logic [7:0] TWS_ITC_WMASK = 8'hBF;

  // Transfer shape
  localparam int TWS_BITS = 8;
  localparam logic [3:0] TWS_BITS_CNT = 4'h8;
  localparam logic [1:0] TWS_BUF_DEPTH = 2'h2;

  // Peer clock half period in ref_clk cycles
  localparam logic [7:0] TWS_PEER_HALF = 8'h04;

endpackage : tws_pkg

// ---- shared/tws_if.sv ----
// Pin bundle joining the device end and the peer end.
// Open-drain lines are resolved here; an enable pulls its line low when o is 0.
`timescale 1ns/1ns
`default_nettype none
interface tws_if;
  logic dev_clk_o;
  logic dev_clk_oe;
  logic dev_a_o;
  logic dev_a_oe;
  logic dev_b_o;
  logic dev_b_oe;
  logic peer_clk_o;
  logic peer_clk_oe;
  logic peer_a_o;
  logic peer_a_oe;
  logic peer_b_o;
  logic peer_b_oe;
  logic clk_line;
  logic a_line;
  logic b_line;

  // Wired-AND of every driver with a pull-up behind it
  assign clk_line = (~dev_clk_oe | dev_clk_o) & (~peer_clk_oe | peer_clk_o);
  assign a_line = (~dev_a_oe | dev_a_o) & (~peer_a_oe | peer_a_o);
  assign b_line = (~dev_b_oe | dev_b_o) & (~peer_b_oe | peer_b_o);

  modport dev (
    output dev_clk_o, dev_clk_oe, dev_a_o, dev_a_oe, dev_b_o, dev_b_oe,
    input clk_line, a_line, b_line
  );
  modport peer (
    output peer_clk_o, peer_clk_oe, peer_a_o, peer_a_oe, peer_b_o, peer_b_oe,
    input clk_line, a_line, b_line
  );
endinterface : tws_if
`default_nettype wire

// ---- design/tws_device.sv ----
// Device end of the two-wire clocked serial port: registers, shift engine,
// pin control and a two-entry receive buffer toward the user side.
// Assumes the user side driving the register port keeps the software-side obligations listed below.
//
// Contract
// - Reset clears mode register to zero
// - Clock select bits pick external or internal
// - Mode bits pick mode and bus pin
// - Unchosen data pin stays ordinary port
// - Software keeps wakeup zero; interrupt every transfer
// - Wakeup in bus mode: interrupt on address match (code matches only with mode bits 4:3 at 10; in two-wire mode 11 no interrupt)
// - Compare flag bit 6, zero when disabled
// - Mode bit 7 enables the channel
// - Reset clears bus control register
// - Release trigger sets output latch, self-clears
// - Command trigger clears output latch, self-clears
// - Software writes zero low nibble; reset clears
// - Clock level indicator reads zero when disabled
// - Shift out MSB first on falling edge
// - Sample data pin on rising edge
// - After eight bits stop and set flag
// - Start only when enabled and clock idle
// - Write while disabled never starts later
// - Software loads all ones before receive
// - Bus pin is open drain following latch
// - Software leaves triggers alone during transfer
// - Software checks errors by compare flag
// - Internal clock: pin level from port latch
`timescale 1ns/1ns
`default_nettype none
module tws_device (
  input wire logic ref_clk,
  input wire logic rst_n,
  tws_if.dev pins,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic timer2_tick,
  input wire logic prescale_tick,
  input wire logic clock_port_latch,
  input wire logic port_dir_clock,
  input wire logic port_latch_a,
  input wire logic port_dir_a,
  input wire logic port_latch_b,
  input wire logic port_dir_b,
  input wire logic flag_clear,
  output logic transfer_end_flag,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);
  import tws_pkg::*;

  typedef enum logic [1:0] {
    TWS_IDLE = 2'b01,
    TWS_SHIFT = 2'b10
  } tws_state_e;

  tws_state_e state_r;
  logic [7:0] mode_r;
  logic [7:0] busctl_r;
  logic [7:0] itc_r;
  logic [7:0] shift_r;
  logic [7:0] sva_r;
  logic data_latch_r;
  logic [3:0] bit_cnt_r;
  logic sck_int_r;
  logic [2:0] clk_sync_r;
  logic [1:0] a_sync_r;
  logic [1:0] b_sync_r;
  logic [7:0] buf_r [2];
  logic [1:0] buf_cnt_r;
  logic buf_rd_r;
  logic buf_wr_r;

  logic enable;
  logic two_wire;
  logic use_pin_a;
  logic internal_clk;
  logic clk_tick;
  logic clk_level;
  logic data_in;
  logic rise_evt;
  logic fall_evt;
  logic done;
  logic start;
  logic compare;
  logic set_flag;
  logic buf_push;
  logic buf_pop;
  logic [7:0] push_byte;
  logic wr_mode;
  logic wr_busctl;

  assign enable = mode_r[TWS_B_ENABLE];
  assign two_wire = mode_r[TWS_B_MODE_HIGH] & mode_r[TWS_B_MODE_MID];
  assign use_pin_a = mode_r[TWS_B_MODE_LOW];
  assign internal_clk = mode_r[TWS_B_CLKSEL_HIGH];
  // Tick source for the internal shift clock
  assign clk_tick = mode_r[TWS_B_CLKSEL_LOW] ? prescale_tick : timer2_tick;
  assign clk_level = clk_sync_r[1];
  assign data_in = use_pin_a ? a_sync_r[1] : b_sync_r[1];
  assign wr_mode = reg_wr && reg_addr == TWS_ADDR_MODE;
  assign wr_busctl = reg_wr && reg_addr == TWS_ADDR_BUSCTL;

  // Shift edges: own divider when internal, line edges when external
  always_comb
  begin
    rise_evt = 1'b0;
    fall_evt = 1'b0;
    if (state_r == TWS_SHIFT)
    begin
      if (internal_clk)
      begin
        rise_evt = clk_tick & ~sck_int_r;
        fall_evt = clk_tick & sck_int_r;
      end
      else
      begin
        rise_evt = clk_sync_r[1] & ~clk_sync_r[2];
        fall_evt = ~clk_sync_r[1] & clk_sync_r[2];
      end
    end
  end

  assign done = rise_evt && bit_cnt_r == TWS_BITS_CNT - 4'h1;
  // Start needs buffer room so a finished byte always has a slot
  assign start = reg_wr && reg_addr == TWS_ADDR_SHIFT && enable && state_r == TWS_IDLE
    && (!internal_clk ? clk_level : sck_int_r) && buf_cnt_r != TWS_BUF_DEPTH;
  assign compare = enable && sva_r == shift_r;
  // Wakeup limits the interrupt to an address match with mode bits 4:3 at 10 and blocks it in every other mode
  assign set_flag = done && (!mode_r[TWS_B_WAKEUP]
    || (mode_r[TWS_B_MODE_HIGH] && !mode_r[TWS_B_MODE_MID]
    && sva_r == {shift_r[6:0], data_in}));
  assign buf_push = done;
  assign buf_pop = rx_valid && rx_ready;
  assign push_byte = {shift_r[6:0], data_in};

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_sync_r <= 3'h7;
      a_sync_r <= 2'h3;
      b_sync_r <= 2'h3;
    end
    else
    begin
      clk_sync_r <= {clk_sync_r[1:0], pins.clk_line};
      a_sync_r <= {a_sync_r[0], pins.a_line};
      b_sync_r <= {b_sync_r[0], pins.b_line};
    end
  end

  // Mode register; compare bit is not stored
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= TWS_MODE_RST;
    else if (wr_mode)
      mode_r <= reg_wdata & TWS_MODE_WMASK;
  end

  // Bus control: trigger bits never stored, they act once then read 0
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      busctl_r <= TWS_BUSCTL_RST;
    else if (wr_busctl)
      busctl_r <= reg_wdata & TWS_BUSCTL_WMASK;
  end

  // Interrupt timing register; clock level bit is live
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      itc_r <= TWS_ITC_RST;
    else if (reg_wr && reg_addr == TWS_ADDR_ITC)
      itc_r <= reg_wdata & TWS_ITC_WMASK;
  end

  // Slave address register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sva_r <= TWS_SVA_RST;
    else if (reg_wr && reg_addr == TWS_ADDR_SVA)
      sva_r <= reg_wdata;
  end

  // Transfer state and bit count
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= TWS_IDLE;
      bit_cnt_r <= 4'h0;
    end
    else
    begin
      case (state_r)
        TWS_IDLE:
        begin
          bit_cnt_r <= 4'h0;
          if (start)
            state_r <= TWS_SHIFT;
        end
        TWS_SHIFT:
        begin
          if (!enable || done)
            state_r <= TWS_IDLE;
          else if (rise_evt)
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        default:
          state_r <= TWS_IDLE;
      endcase
    end
  end

  // Shift register: writes load only when idle; bits enter at the bottom
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_r <= TWS_SHIFT_RST;
    else if (rise_evt)
      shift_r <= {shift_r[6:0], data_in};
    else if (reg_wr && reg_addr == TWS_ADDR_SHIFT && state_r == TWS_IDLE)
      shift_r <= reg_wdata;
  end

  // Output latch: MSB on falling edge, triggers only while enabled
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      data_latch_r <= 1'b0;
    else if (fall_evt)
      data_latch_r <= shift_r[7];
    else if (wr_busctl && enable && reg_wdata[TWS_B_RELEASE])
      data_latch_r <= 1'b1;
    else if (wr_busctl && enable && reg_wdata[TWS_B_COMMAND])
      data_latch_r <= 1'b0;
  end

  // Internal clock rests high and toggles on each tick while shifting
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sck_int_r <= 1'b1;
    else if (state_r != TWS_SHIFT || !internal_clk)
      sck_int_r <= 1'b1;
    else if (clk_tick)
      sck_int_r <= ~sck_int_r;
  end

  // End flag: a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      transfer_end_flag <= 1'b0;
    else if (set_flag)
      transfer_end_flag <= 1'b1;
    else if (flag_clear)
      transfer_end_flag <= 1'b0;
  end

  // Pin drivers, registered
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins.dev_clk_o <= 1'b1;
      pins.dev_clk_oe <= 1'b0;
      pins.dev_a_o <= 1'b1;
      pins.dev_a_oe <= 1'b0;
      pins.dev_b_o <= 1'b1;
      pins.dev_b_oe <= 1'b0;
    end
    else
    begin
      // Clock pin open drain, low when latch or internal clock is low
      pins.dev_clk_o <= 1'b0;
      pins.dev_clk_oe <= two_wire && enable && internal_clk && !port_dir_clock
        && !(clock_port_latch && sck_int_r);
      // Unchosen pin is a push-pull port pin; direction 0 means output
      pins.dev_a_o <= (two_wire && enable && use_pin_a) ? 1'b0 : port_latch_a;
      pins.dev_a_oe <= (two_wire && enable && use_pin_a) ? !data_latch_r : !port_dir_a;
      pins.dev_b_o <= (two_wire && enable && !use_pin_a) ? 1'b0 : port_latch_b;
      pins.dev_b_oe <= (two_wire && enable && !use_pin_a) ? !data_latch_r : !port_dir_b;
    end
  end

  // Register read data, one cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        TWS_ADDR_MODE: reg_rdata <= {mode_r[7], compare, mode_r[5:0]};
        TWS_ADDR_BUSCTL: reg_rdata <= busctl_r;
        TWS_ADDR_ITC: reg_rdata <= {itc_r[7], enable & clk_level, itc_r[5:0]};
        TWS_ADDR_SHIFT: reg_rdata <= shift_r;
        TWS_ADDR_SVA: reg_rdata <= sva_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Two-entry receive buffer; full buffer blocks the next start
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_cnt_r <= 2'h0;
      buf_rd_r <= 1'b0;
      buf_wr_r <= 1'b0;
      buf_r[0] <= 8'h00;
      buf_r[1] <= 8'h00;
    end
    else
    begin
      if (buf_push)
      begin
        buf_r[buf_wr_r] <= {shift_r[6:0], data_in};
        buf_wr_r <= ~buf_wr_r;
      end
      if (buf_pop)
        buf_rd_r <= ~buf_rd_r;
      buf_cnt_r <= buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // Registered stream head
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end
    else
    begin
      rx_valid <= (buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop}) != 2'h0;
      // An emptied buffer takes the arriving byte straight to the head,
      // otherwise valid would rise over a slot still being written
      rx_data <= (buf_cnt_r - {1'b0, buf_pop} == 2'h0) ? push_byte
        : buf_r[buf_rd_r ^ buf_pop];
    end
  end

endmodule : tws_device
`default_nettype wire

// ---- design/tws_peer.sv ----
// Peer end: a clocked serial controller on the far side of the two wires.
// Either drives the clock itself or follows the device's clock.
// Assumes the device keeps the pins open drain with pull-ups.
`timescale 1ns/1ns
`default_nettype none
module tws_peer (
  input wire logic ref_clk,
  input wire logic rst_n,
  tws_if.peer pins,
  input wire logic use_pin_a,
  input wire logic drive_clock,
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  output logic busy,
  output logic [7:0] rx_byte,
  output logic rx_done
);
  import tws_pkg::*;

  logic [2:0] clk_sync_r;
  logic [1:0] a_sync_r;
  logic [1:0] b_sync_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] div_r;
  logic sck_r;
  logic data_r;
  logic data_in;
  logic rise_evt;
  logic fall_evt;
  logic half;

  assign data_in = use_pin_a ? a_sync_r[1] : b_sync_r[1];
  assign half = div_r == TWS_PEER_HALF - 8'h01;
  assign rise_evt = busy && (drive_clock ? (half && !sck_r) : (clk_sync_r[1] && !clk_sync_r[2]));
  assign fall_evt = busy && (drive_clock ? (half && sck_r) : (!clk_sync_r[1] && clk_sync_r[2]));

  // Line synchronisers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_sync_r <= 3'h7;
      a_sync_r <= 2'h3;
      b_sync_r <= 2'h3;
    end
    else
    begin
      clk_sync_r <= {clk_sync_r[1:0], pins.clk_line};
      a_sync_r <= {a_sync_r[0], pins.a_line};
      b_sync_r <= {b_sync_r[0], pins.b_line};
    end
  end

  // Own clock generator, resting high between bytes
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r <= 8'h00;
      sck_r <= 1'b1;
    end
    else if (!busy || !drive_clock)
    begin
      div_r <= 8'h00;
      sck_r <= 1'b1;
    end
    else if (half)
    begin
      div_r <= 8'h00;
      sck_r <= ~sck_r;
    end
    else
      div_r <= div_r + 8'h01;
  end

  // Byte engine: MSB out on falling edge, sample on rising edge
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      shift_r <= 8'hFF;
      bit_cnt_r <= 4'h0;
      data_r <= 1'b1;
      rx_byte <= 8'h00;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (!busy && tx_start)
      begin
        busy <= 1'b1;
        shift_r <= tx_data;
        bit_cnt_r <= 4'h0;
      end
      else if (fall_evt)
        data_r <= shift_r[7];
      else if (rise_evt)
      begin
        shift_r <= {shift_r[6:0], data_in};
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (bit_cnt_r == TWS_BITS_CNT - 4'h1)
        begin
          busy <= 1'b0;
          rx_byte <= {shift_r[6:0], data_in};
          rx_done <= 1'b1;
        end
      end
      else if (!busy)
        data_r <= 1'b1; // A cycle after the last rise, never together with it
    end
  end

  // Open-drain drivers, registered
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins.peer_clk_o <= 1'b0;
      pins.peer_clk_oe <= 1'b0;
      pins.peer_a_o <= 1'b0;
      pins.peer_a_oe <= 1'b0;
      pins.peer_b_o <= 1'b0;
      pins.peer_b_oe <= 1'b0;
    end
    else
    begin
      pins.peer_clk_o <= 1'b0;
      pins.peer_clk_oe <= drive_clock && busy && !sck_r;
      pins.peer_a_o <= 1'b0;
      pins.peer_a_oe <= use_pin_a && !data_r;
      pins.peer_b_o <= 1'b0;
      pins.peer_b_oe <= !use_pin_a && !data_r;
    end
  end

endmodule : tws_peer
`default_nettype wire

// ---- bench/tws_monitor.sv ----
// Checker for the two-wire link: resolved lines and both ends' drivers.
// Assumes the bench clock and reset, and a place beside the link interface.
`timescale 1ns/1ns
`default_nettype none
module tws_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic dev_clk_o,
  input wire logic dev_clk_oe,
  input wire logic dev_a_o,
  input wire logic dev_a_oe,
  input wire logic dev_b_o,
  input wire logic dev_b_oe,
  input wire logic peer_clk_o,
  input wire logic peer_clk_oe,
  input wire logic peer_a_o,
  input wire logic peer_a_oe,
  input wire logic peer_b_o,
  input wire logic peer_b_oe,
  input wire logic clk_line,
  input wire logic a_line,
  input wire logic b_line
);
  default clocking mon_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic peer_low;
  logic clk_d_r;
  logic [4:0] idle_r;
  logic [3:0] rises_r;

  // Peer pulls the clock line low
  assign peer_low = peer_clk_oe & ~peer_clk_o;

  // Length of the current high spell on the clock line, saturating
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_d_r <= 1'b1;
      idle_r <= 5'h00;
    end
    else
    begin
      clk_d_r <= clk_line;
      idle_r <= !clk_line ? 5'h00 : idle_r + {4'h0, idle_r != 5'h1F};
    end
  end

  // Rises per frame; a long idle closes the frame, so bit clocks never spill over
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rises_r <= 4'h0;
    else if (idle_r == 5'h1F)
      rises_r <= 4'h0;
    else if (clk_line && !clk_d_r)
      rises_r <= rises_r + {3'h0, rises_r != 4'hF};
  end

  chk_reset_dev_quiet:
    assert property ($rose(rst_n) |-> !dev_clk_oe && !dev_a_oe && !dev_b_oe)
    else $error("Device drives a pin right after reset");
  chk_reset_peer_quiet:
    assert property ($rose(rst_n) |-> !peer_clk_oe && !peer_a_oe && !peer_b_oe)
    else $error("Peer drives a pin right after reset");
  chk_lines_released:
    assert property ($rose(rst_n) |-> clk_line && a_line && b_line)
    else $error("Link line low right after reset");
  chk_dev_data_steady:
    assert property ($fell(dev_clk_oe) |-> $stable(dev_a_oe) && $stable(dev_a_o)
      && $stable(dev_b_oe) && $stable(dev_b_o))
    else $error("Device data moved at the clock rise");
  chk_clock_one_owner:
    assert property (!(dev_clk_oe && !dev_clk_o && peer_low))
    else $error("Both ends pull the clock line low");
  chk_peer_half_period:
    assert property ($rose(peer_low) |-> peer_low [*4] ##1 !peer_low)
    else $error("Peer clock low phase not four cycles");
  chk_peer_data_steady:
    assert property ($fell(peer_low) |-> $stable(peer_a_o) && $stable(peer_a_oe)
      && $stable(peer_b_o) && $stable(peer_b_oe))
    else $error("Peer data moved at the clock rise");
  chk_frame_eight:
    assert property (rises_r <= 4'h8)
    else $error("More than eight clock rises in one frame");
endmodule : tws_monitor
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench: device end and peer end joined by the link interface.
// Assumes the package map and the hand-over timing of both ends.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tws_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic prescale_tick = 1'b0;
  logic timer2_tick = 1'b0;
  logic clock_port_latch = 1'b1;
  logic port_dir_clock = 1'b1;
  logic port_dir_a = 1'b1;
  logic port_latch_b = 1'b0;
  logic port_dir_b = 1'b1;
  logic flag_clear = 1'b0;
  logic transfer_end_flag;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_ready = 1'b0;
  logic drive_clock = 1'b0;
  logic tx_start = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] rx_byte;
  logic rx_done;
  logic peer_busy;
  logic rd_d = 1'b0;
  logic [7:0] d;
  logic [7:0] e;
  logic [7:0] reg_q[$];
  logic [7:0] rx_q[$];
  logic [7:0] pk_q[$];
  int checks = 0;
  int n_fail = 0;

  tws_if lnk ();

  // Both ends face each other; user sides are driven from here
  tws_device tws_device_i (.ref_clk, .rst_n, .pins(lnk.dev), .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .timer2_tick, .prescale_tick, .clock_port_latch,
    .port_dir_clock, .port_latch_a(1'b0), .port_dir_a, .port_latch_b, .port_dir_b,
    .flag_clear, .transfer_end_flag, .rx_data, .rx_valid, .rx_ready);
  tws_peer tws_peer_i (.ref_clk, .rst_n, .pins(lnk.peer), .use_pin_a(1'b1), .drive_clock,
    .tx_start, .tx_data, .busy(peer_busy), .rx_byte, .rx_done);
  tws_monitor tws_monitor_i (.ref_clk, .rst_n, .dev_clk_o(lnk.dev_clk_o),
    .dev_clk_oe(lnk.dev_clk_oe), .dev_a_o(lnk.dev_a_o), .dev_a_oe(lnk.dev_a_oe),
    .dev_b_o(lnk.dev_b_o), .dev_b_oe(lnk.dev_b_oe), .peer_clk_o(lnk.peer_clk_o),
    .peer_clk_oe(lnk.peer_clk_oe), .peer_a_o(lnk.peer_a_o), .peer_a_oe(lnk.peer_a_oe),
    .peer_b_o(lnk.peer_b_o), .peer_b_oe(lnk.peer_b_oe), .clk_line(lnk.clk_line),
    .a_line(lnk.a_line), .b_line(lnk.b_line));

  // 125 MHz reference
  always #4 ref_clk = ~ref_clk;

  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_pin(input logic got, input logic exp, input string what);
    cmp_byte({7'h00, got}, {7'h00, exp}, what);
  endtask : cmp_pin

  task automatic wr(input logic [15:0] a, input logic [7:0] dat);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // The read answer is checked by the watcher one cycle later
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    reg_q.push_back(exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic ptx(input logic [7:0] dat, input logic drv);
    @(posedge ref_clk);
    drive_clock <= drv;
    tx_data <= dat;
    tx_start <= 1'b1;
    @(posedge ref_clk);
    tx_start <= 1'b0;
  endtask : ptx

  // Bounded wait for the end flag; tick bit 0 feeds the prescaler, bit 1 timer 2
  task automatic run(input logic [1:0] tick, input logic want);
    int i;
    for (i = 0; i < 600; i++)
    begin
      @(posedge ref_clk);
      if (want && transfer_end_flag === 1'b1)
        break;
      prescale_tick <= tick[0] & (i % 8 == 0);
      timer2_tick <= tick[1] & (i % 8 == 0);
    end
    @(posedge ref_clk);
    prescale_tick <= 1'b0;
    timer2_tick <= 1'b0;
    if (want && i == 600)
    begin
      n_fail++;
      $display("mismatch at %0t: no end flag", $time);
      tally_and_finish();
    end
    else
      cmp_pin(transfer_end_flag, want, "end flag");
  endtask : run

  task automatic clr;
    @(posedge ref_clk);
    flag_clear <= 1'b1;
    @(posedge ref_clk);
    flag_clear <= 1'b0;
    @(posedge ref_clk);
    cmp_pin(transfer_end_flag, 1'b0, "flag clear");
  endtask : clr

  // Watcher: oldest note against each result as it appears
  always @(posedge ref_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      cmp_byte(reg_rdata, reg_q.size() ? reg_q.pop_front() : 8'hXX, "read");
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      cmp_byte(rx_data, rx_q.size() ? rx_q.pop_front() : 8'hXX, "rx");
    if (rx_done === 1'b1)
      cmp_byte(rx_byte, pk_q.size() ? pk_q.pop_front() : 8'hXX, "peer");
  end

  initial
  begin
    void'($urandom(57651));
    d = 8'($urandom) | 8'h01;
    e = 8'($urandom);
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    port_dir_a <= 1'b0;
    port_dir_b <= 1'b0;
    port_dir_clock <= 1'b0;
    port_latch_b <= e[0];
    rd(TWS_ADDR_MODE, 8'h00);
    rd(TWS_ADDR_BUSCTL, 8'h00);
    rd(TWS_ADDR_ITC, 8'h00);
    rd(16'hFFF0, 8'h00);
    wr(TWS_ADDR_MODE, 8'h40);
    rd(TWS_ADDR_MODE, 8'h00);
    wr(TWS_ADDR_ITC, 8'hA0);
    rd(TWS_ADDR_ITC, 8'hA0);
    $display("test reset_values done");
    // Enable, two-wire on pin a, internal prescale clock; shift 00 differs from d
    wr(TWS_ADDR_SVA, d);
    wr(TWS_ADDR_MODE, 8'h9F);
    rd(TWS_ADDR_MODE, 8'h9F);
    rd(TWS_ADDR_ITC, 8'hE0);
    wr(TWS_ADDR_BUSCTL, 8'h01);
    repeat (4) @(posedge ref_clk);
    cmp_pin(lnk.a_line, 1'b1, "release");
    rd(TWS_ADDR_BUSCTL, 8'h00);
    wr(TWS_ADDR_BUSCTL, 8'h02);
    repeat (4) @(posedge ref_clk);
    cmp_pin(lnk.a_line, 1'b0, "command");
    rd(TWS_ADDR_BUSCTL, 8'h00);
    wr(TWS_ADDR_BUSCTL, 8'h01);
    cmp_pin(lnk.b_line, e[0], "port b");
    cmp_pin(lnk.clk_line, 1'b1, "clock idle");
    // Port latch low pulls the idle clock pin; the level bit follows the line
    clock_port_latch <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cmp_pin(lnk.clk_line, 1'b0, "clock latch");
    rd(TWS_ADDR_ITC, 8'hA0);
    clock_port_latch <= 1'b1;
    $display("test triggers done");
    // Write while disabled must not start once enabled
    wr(TWS_ADDR_MODE, 8'h1F);
    wr(TWS_ADDR_SHIFT, e);
    wr(TWS_ADDR_MODE, 8'h9F);
    run(2'b01, 1'b0);
    $display("test disabled_write done");
    // Device clocks out d while the peer sends all ones
    wr(TWS_ADDR_BUSCTL, 8'h01);
    ptx(8'hFF, 1'b0);
    rx_q.push_back(d);
    pk_q.push_back(d);
    wr(TWS_ADDR_SHIFT, d);
    run(2'b01, 1'b1);
    rd(TWS_ADDR_MODE, 8'hDF);
    clr();
    $display("test device_master done");
    // Idle gap long enough for the checker to close the last frame
    repeat (40) @(posedge ref_clk);
    // Peer clocks e in; device shift loaded with all ones releases the line
    wr(TWS_ADDR_MODE, 8'h9C);
    wr(TWS_ADDR_BUSCTL, 8'h01);
    wr(TWS_ADDR_SHIFT, 8'hFF);
    rx_q.push_back(e);
    pk_q.push_back(e);
    ptx(e, 1'b1);
    run(2'b00, 1'b1);
    clr();
    $display("test peer_master done");
    // Two bytes pending with the reader stalled: a further start is refused
    wr(TWS_ADDR_MODE, 8'h9F);
    wr(TWS_ADDR_SHIFT, d);
    run(2'b01, 1'b0);
    repeat (60) @(posedge ref_clk) rx_ready <= 1'($urandom);
    @(posedge ref_clk) rx_ready <= 1'b1;
    repeat (6) @(posedge ref_clk);
    cmp_byte(8'(rx_q.size()), 8'h00, "drain");
    $display("test buffer done");
    // Timer 2 ticks drive the shift clock; the reader takes the byte at once
    wr(TWS_ADDR_MODE, 8'h9E);
    ptx(8'hFF, 1'b0);
    rx_q.push_back(e);
    pk_q.push_back(e);
    wr(TWS_ADDR_SHIFT, e);
    run(2'b10, 1'b1);
    clr();
    repeat (4) @(posedge ref_clk);
    cmp_byte(8'(rx_q.size() + pk_q.size()), 8'h00, "both drained");
    cmp_pin(peer_busy, 1'b0, "peer idle");
    $display("test timer2 done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
